// File: fls_params.svh
`ifndef FLS_PARAMS_SVH
`define FLS_PARAMS_SVH

// opcodes
`define FLS_OP_UID 8'h4b
`define FLS_OP_WIDE_ON 8'hb7
`define FLS_OP_WIDE_OFF 8'he9
`define FLS_OP_CLR_FLAGS 8'h30
`define FLS_OP_RELEASE 8'hab
`define FLS_OP_DEEP_PD 8'hb9
`define FLS_OP_MDID_1 8'h90
`define FLS_OP_MDID_2 8'h92
`define FLS_OP_MDID_4 8'h94
`define FLS_OP_IDENT3 8'h9f

// phase lengths: opcode and dummy as index of the last serial clock, address as a bit count
`define FLS_OPC_LAST 6'h07
`define FLS_UID_DUMMY_NARROW 6'h1f
`define FLS_UID_DUMMY_WIDE 6'h27
`define FLS_DEVID_DUMMY 6'h17
`define FLS_ADDR_BITS_NARROW 6'h18
`define FLS_ADDR_BITS_WIDE 6'h20

// output stream lengths in bits
`define FLS_LEN_UID 8'h80
`define FLS_LEN_IDENT 8'h18
`define FLS_LEN_MDID 8'h10
`define FLS_LEN_DEVID 8'h08

// reset values
`define FLS_ADDR_LEN_RST 1'b0
`define FLS_LANES_RST 3'h1

// release recovery time
`define FLS_CORE_CLK_NS 8
`define FLS_T_RELEASE_NS 3000
`define FLS_REL_CYC (((`FLS_T_RELEASE_NS) + (`FLS_CORE_CLK_NS) - 1) / (`FLS_CORE_CLK_NS))
`define FLS_REL_W 9

`endif

// File: fls_pkg.sv
package fls_pkg;

	// serial frame phase
	typedef enum logic [4:0] {
		FLS_OPC = 5'h01,
		FLS_ADDR = 5'h02,
		FLS_DUMMY = 5'h04,
		FLS_OUT = 5'h08,
		FLS_IDLE = 5'h10
	} fls_phase_t;

	// which identification stream is shifted out
	typedef enum logic [3:0] {
		FLS_K_UID = 4'h1,
		FLS_K_IDENT = 4'h2,
		FLS_K_MDID = 4'h4,
		FLS_K_DEVID = 4'h8
	} fls_kind_t;

	typedef struct packed {
		fls_phase_t phase;
		logic [5:0] cnt;
		logic [5:0] last;
		logic [7:0] opc;
		fls_kind_t kind;
		logic [2:0] lanes;
		logic swap;
		logic sgl;
	} fls_frame_t;

	typedef struct packed {
		logic [7:0] cmd;
		logic ev_tgl;
		logic cn_tgl;
		logic [3:0] f1;
		logic [3:0] f2;
	} fls_linkp_t;

	typedef struct packed {
		logic [7:0] idx;
		logic [3:0] io_out;
		logic [3:0] io_oe;
	} fls_out_t;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_p;
		logic ev_s1;
		logic ev_s2;
		logic ev_p;
		logic cn_s1;
		logic cn_s2;
		logic cn_p;
		logic pend;
		logic [7:0] code;
		logic alf;
		logic perr;
		logic eerr;
		logic dpd;
		logic rec;
		logic [8:0] rec_cnt;
		logic write_in_progress;
	} fls_core_t;

endpackage

// File: fls_id_cmds.sv
`timescale 1ns/10ps
// Behaviour
// - opcode 4B returns a fixed, read-only 128-bit value unique per part
// - narrow mode: unique-ID opcode, four dummy bytes, 128 bits out, host ends
// - wide mode: unique-ID opcode needs five dummy bytes before the 128 bits
// - after reset addresses decode as 24 bits
// - opcode B7 sets the address-length flag; address commands take 32 bits
// - in wide mode all commands work as before, only address length and unique-ID dummy count change
// - opcode E9 clears the address-length flag, back to 24-bit decoding
// - opcode 30 clears the program-error and erase-error flags
// - flag clear needs no write enable and leaves the write-enable latch alone
// - flag clear is refused while write-in-progress is set
// - after release opcode AB wait recovery time before accepting commands
// - AB with three dummy bytes repeats the device ID MSB first on falling edges
// - AB is ignored during a running erase, program or write cycle
// - 90 with address 0 returns maker ID then device ID, MSB first
// - address 1 in a maker/device ID read puts device ID first
// - 92 is the maker/device ID read over two data lines
// - 94 is the maker/device ID read over four data lines
// - 9F returns maker code, memory type, capacity, one bit per falling edge
// - 9F is not decoded while erase or program runs
// - chip select high ends an ID read at any point; device goes standby
// - in deep power-down every command except release is ignored
// - write-in-progress reads 1 through any self-timed cycle, 0 after
`include "fls_params.svh"

module fls_id_cmds #(
	parameter logic [127:0] UID_VALUE = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0, // arbitrary
	parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary
	parameter logic [7:0] DEVICE_ID = 8'h3c, // arbitrary
	parameter logic [7:0] MEM_TYPE = 8'h41, // arbitrary
	parameter logic [7:0] CAPACITY = 8'h1a // arbitrary
) (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io_in,
	input wire logic i_cycle_busy,
	input wire logic i_program_fail,
	input wire logic i_erase_fail,
	output logic [3:0] o_io_out,
	output logic [3:0] o_io_oe,
	output logic o_addr_len_flag,
	output logic o_program_error_flag,
	output logic o_erase_error_flag,
	output logic o_write_in_progress,
	output logic o_deep_power_down,
	output logic o_recovering
);
	import fls_pkg::*;

	localparam int REL_MAX = 400;

	fls_frame_t fr, nf;
	fls_linkp_t lp, np;
	fls_out_t ol, no;
	fls_core_t cr, nc;
	logic frame_clr;
	logic exec_now;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_single(input logic [7:0] op);
		return (op == `FLS_OP_WIDE_ON) || (op == `FLS_OP_WIDE_OFF) ||
			(op == `FLS_OP_CLR_FLAGS) || (op == `FLS_OP_RELEASE) ||
			(op == `FLS_OP_DEEP_PD);
	endfunction

	// last clock index of the address phase for the lane count
	function automatic logic [5:0] addr_last(input logic wide, input logic [2:0] lanes);
		logic [5:0] bits;
		bits = wide ? `FLS_ADDR_BITS_WIDE : `FLS_ADDR_BITS_NARROW;
		if (lanes == 3'h4) begin
			return (bits >> 2) - 6'h01;
		end else if (lanes == 3'h2) begin
			return (bits >> 1) - 6'h01;
		end
		return bits - 6'h01;
	endfunction

	// identification stream, left aligned in 128 bits
	function automatic logic [127:0] stream(input fls_kind_t kind, input logic swap);
		unique case (kind)
			FLS_K_UID: return UID_VALUE;
			FLS_K_IDENT: return {MAKER_ID, MEM_TYPE, CAPACITY, 104'h0};
			FLS_K_MDID: return swap ? {DEVICE_ID, MAKER_ID, 112'h0}
				: {MAKER_ID, DEVICE_ID, 112'h0};
			FLS_K_DEVID: return {DEVICE_ID, 120'h0};
			default: return 128'h0;
		endcase
	endfunction

	function automatic logic [7:0] stream_len(input fls_kind_t kind);
		unique case (kind)
			FLS_K_UID: return `FLS_LEN_UID;
			FLS_K_IDENT: return `FLS_LEN_IDENT;
			FLS_K_MDID: return `FLS_LEN_MDID;
			FLS_K_DEVID: return `FLS_LEN_DEVID;
			default: return `FLS_LEN_DEVID;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// link domain: frame decode on rising serial clock

	// chip select high ends any frame at once and returns to standby
	assign frame_clr = i_cs_n | i_reset;

	always_comb begin
		logic [7:0] op;
		op = {fr.opc[6:0], i_io_in[0]};
		nf = fr;
		nf.cnt = fr.cnt + 6'h01;
		unique case (fr.phase)
			FLS_OPC: begin
				nf.opc = op;
				if (fr.cnt == `FLS_OPC_LAST) begin
					nf.cnt = 6'h00;
					nf.phase = FLS_IDLE;
					nf.sgl = is_single(op) && (op != `FLS_OP_RELEASE);
					nf.lanes = `FLS_LANES_RST;
					// recovery masks every opcode, deep power-down masks all but release
					if (!(lp.f2[3] || (lp.f2[2] && (op != `FLS_OP_RELEASE)))) begin
						case (op)
							`FLS_OP_UID: begin
								nf.phase = FLS_DUMMY;
								nf.kind = FLS_K_UID;
								nf.last = lp.f2[0] ? `FLS_UID_DUMMY_WIDE
									: `FLS_UID_DUMMY_NARROW;
							end
							`FLS_OP_RELEASE: begin
								if (!lp.f2[1]) begin
									nf.phase = FLS_DUMMY;
									nf.kind = FLS_K_DEVID;
									nf.last = `FLS_DEVID_DUMMY;
								end
							end
							`FLS_OP_IDENT3: begin
								if (!lp.f2[1]) begin
									nf.phase = FLS_OUT;
									nf.kind = FLS_K_IDENT;
								end
							end
							`FLS_OP_MDID_1, `FLS_OP_MDID_2, `FLS_OP_MDID_4: begin
								nf.phase = FLS_ADDR;
								nf.kind = FLS_K_MDID;
								nf.lanes = (op == `FLS_OP_MDID_4) ? 3'h4
									: (op == `FLS_OP_MDID_2) ? 3'h2 : 3'h1;
								// only the address length follows the mode flag
								nf.last = addr_last(lp.f2[0], nf.lanes);
							end
							default: begin
							end
						endcase
					end
				end
			end
			FLS_ADDR: begin
				// the last address clock carries bit 0 on line 0
				if (fr.cnt == fr.last) begin
					nf.phase = FLS_OUT;
					nf.swap = i_io_in[0];
				end
			end
			FLS_DUMMY: begin
				if (fr.cnt == fr.last) begin
					nf.phase = FLS_OUT;
				end
			end
			FLS_OUT, FLS_IDLE: begin
				nf.cnt = fr.cnt;
				nf.sgl = 1'b0;
			end
			default: begin
				nf.phase = FLS_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			fr <= '0;
			fr.phase <= FLS_OPC;
			fr.kind <= FLS_K_UID;
			fr.lanes <= `FLS_LANES_RST;
		end else begin
			fr <= nf;
		end
	end

	// command hand-off and status synchronisers on the serial clock
	always_comb begin
		logic [7:0] op;
		op = {fr.opc[6:0], i_io_in[0]};
		np = lp;
		np.f1 = {o_recovering, o_deep_power_down, o_write_in_progress, o_addr_len_flag};
		np.f2 = lp.f1;
		if ((fr.phase == FLS_OPC) && (fr.cnt == `FLS_OPC_LAST)) begin
			np.cmd = op;
			if (is_single(op)) begin
				np.ev_tgl = ~lp.ev_tgl;
			end
		end
		// a ninth clock after a lone opcode other than release voids the command
		if ((fr.phase == FLS_IDLE) && fr.sgl) begin
			np.cn_tgl = ~lp.cn_tgl;
		end
	end

	always_ff @(posedge i_sclk or posedge i_reset) begin
		if (i_reset) begin
			lp <= '0;
		end else begin
			lp <= np;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: data out on falling serial clock

	always_comb begin
		logic [127:0] vec;
		logic [7:0] p;
		logic [7:0] nidx;
		vec = stream(fr.kind, fr.swap);
		p = 8'h00;
		nidx = ol.idx + 8'(fr.lanes);
		no = ol;
		no.io_oe = 4'h0;
		if (fr.phase == FLS_OUT) begin
			if (fr.lanes == 3'h1) begin
				// single line answers on line 1, MSB first
				no.io_out = {2'h0, vec[7'(8'h7f - ol.idx)], 1'b0};
				no.io_oe = 4'h2;
			end else begin
				for (int j = 0; j < 4; j++) begin
					if (j < int'(fr.lanes)) begin
						p = ol.idx + 8'(fr.lanes) - 8'(j) - 8'h01;
						no.io_out[j] = vec[7'(8'h7f - p)];
						no.io_oe[j] = 1'b1;
					end else begin
						no.io_out[j] = 1'b0;
					end
				end
			end
			// wrap the stream so reads repeat until deselect
			no.idx = (nidx == stream_len(fr.kind)) ? 8'h00 : nidx;
		end
	end

	always_ff @(negedge i_sclk or posedge frame_clr) begin
		if (frame_clr) begin
			ol <= '0;
		end else begin
			ol <= no;
		end
	end

	assign o_io_out = ol.io_out;
	assign o_io_oe = ol.io_oe;

	////////////////////////////////////////////////////////////////////////
	// core domain: command execution and status

	always_comb begin
		logic clr;
		clr = 1'b0;
		nc = cr;
		exec_now = 1'b0;
		nc.cs_s1 = i_cs_n;
		nc.cs_s2 = cr.cs_s1;
		nc.cs_p = cr.cs_s2;
		nc.ev_s1 = lp.ev_tgl;
		nc.ev_s2 = cr.ev_s1;
		nc.ev_p = cr.ev_s2;
		nc.cn_s1 = lp.cn_tgl;
		nc.cn_s2 = cr.cn_s1;
		nc.cn_p = cr.cn_s2;
		nc.write_in_progress = i_cycle_busy;
		if (cr.ev_s2 != cr.ev_p) begin
			nc.pend = 1'b1;
			nc.code = lp.cmd;
		end
		if (cr.cn_s2 != cr.cn_p) begin
			nc.pend = 1'b0;
		end
		// recovery countdown
		if (cr.rec) begin
			nc.rec_cnt = cr.rec_cnt - 9'h001;
			if (cr.rec_cnt == 9'h001) begin
				nc.rec = 1'b0;
			end
		end
		// lone opcodes act when chip select rises
		if (cr.cs_s2 && !cr.cs_p && cr.pend) begin
			exec_now = 1'b1;
			nc.pend = 1'b0;
			if (!cr.rec) begin
				case (cr.code)
					`FLS_OP_WIDE_ON: nc.alf = cr.dpd ? cr.alf : 1'b1;
					`FLS_OP_WIDE_OFF: nc.alf = cr.dpd ? cr.alf : 1'b0;
					// write-enable latch is not involved
					`FLS_OP_CLR_FLAGS: clr = !cr.dpd && !cr.write_in_progress;
					`FLS_OP_DEEP_PD: nc.dpd = cr.dpd || !cr.write_in_progress;
					`FLS_OP_RELEASE: begin
						if (cr.dpd && !cr.write_in_progress) begin
							nc.dpd = 1'b0;
							nc.rec = 1'b1;
							nc.rec_cnt = 9'(`FLS_REL_CYC);
						end
					end
					default: begin
					end
				endcase
			end
		end
		// a new failure wins over a clear in the same cycle
		nc.perr = (cr.perr && !clr) || i_program_fail;
		nc.eerr = (cr.eerr && !clr) || i_erase_fail;
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			cr <= '0;
			cr.cs_s1 <= 1'b1;
			cr.cs_s2 <= 1'b1;
			cr.cs_p <= 1'b1;
			cr.alf <= `FLS_ADDR_LEN_RST;
		end else begin
			cr <= nc;
		end
	end

	assign o_addr_len_flag = cr.alf;
	assign o_program_error_flag = cr.perr;
	assign o_erase_error_flag = cr.eerr;
	assign o_write_in_progress = cr.write_in_progress;
	assign o_deep_power_down = cr.dpd;
	assign o_recovering = cr.rec;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	property p_wide_on;
		exec_now && (cr.code == `FLS_OP_WIDE_ON) && !cr.dpd && !cr.rec |=> o_addr_len_flag;
	endproperty
	a_wide_on: assert property (p_wide_on) else $error("wide mode not entered");

	property p_wide_off;
		exec_now && (cr.code == `FLS_OP_WIDE_OFF) && !cr.dpd && !cr.rec
			|=> !o_addr_len_flag;
	endproperty
	a_wide_off: assert property (p_wide_off) else $error("wide mode not left");

	property p_reset_narrow;
		$past(i_reset) |-> !o_addr_len_flag;
	endproperty
	a_reset_narrow: assert property (p_reset_narrow) else $error("wide after reset");

	property p_clear_flags;
		exec_now && (cr.code == `FLS_OP_CLR_FLAGS) && !cr.write_in_progress && !cr.dpd && !cr.rec &&
			!i_program_fail && !i_erase_fail |=> !o_program_error_flag && !o_erase_error_flag;
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

	property p_clear_busy;
		exec_now && (cr.code == `FLS_OP_CLR_FLAGS) && o_write_in_progress && o_erase_error_flag
			|=> o_erase_error_flag;
	endproperty
	a_clear_busy: assert property (p_clear_busy) else $error("clear taken while busy");

	property p_release_busy;
		exec_now && (cr.code == `FLS_OP_RELEASE) && o_write_in_progress
			|=> $stable(o_deep_power_down) && !$rose(o_recovering);
	endproperty
	a_release_busy: assert property (p_release_busy) else $error("release while busy");

	property p_recovery;
		$rose(o_recovering) |-> o_recovering [*8] ##[1:REL_MAX] !o_recovering;
	endproperty
	a_recovery: assert property (p_recovery) else $error("recovery length wrong");

	property p_pd_ignore;
		exec_now && (cr.code == `FLS_OP_WIDE_ON) && o_deep_power_down
			|=> $stable(o_addr_len_flag);
	endproperty
	a_pd_ignore: assert property (p_pd_ignore) else $error("command taken in power-down");

	property p_wip_follow;
		!$past(i_reset) |-> (o_write_in_progress == $past(i_cycle_busy));
	endproperty
	a_wip_follow: assert property (p_wip_follow) else $error("busy flag lags");

	c_wide_on: cover property (exec_now && (cr.code == `FLS_OP_WIDE_ON));
	c_clear: cover property (exec_now && (cr.code == `FLS_OP_CLR_FLAGS));
	c_release: cover property ($rose(o_recovering));
	c_wide_off: cover property ($fell(o_addr_len_flag));

endmodule

// File: fls_host_model.sv
`timescale 1ns/10ps
module fls_host_model (
	input wire logic [3:0] i_io_out,
	input wire logic [3:0] i_io_oe,
	output logic o_sclk,
	output logic o_cs_n,
	output logic [3:0] o_io
);
	logic [3:0] drv;
	logic oe_seen;

	//////////////////////////////////////////////////////////////////
	// wire level: the device wins on lines it enables, else host value
	assign o_io = (i_io_oe & i_io_out) | (~i_io_oe & drv);

	// idle: deselected, serial clock parked low
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		drv = 4'h0;
		oe_seen = 1'b0;
	end

	//////////////////////////////////////////////////////////////////
	// one serial clock; released lines flip so no stale value survives
	task automatic tick(input logic [3:0] d, input logic [3:0] en, output logic [3:0] q);
		drv = (d & en) | (~drv & ~en);
		#62.5 o_sclk = 1'b1;
		q = o_io;
		oe_seen = oe_seen | (|i_io_oe);
		#62.5 o_sclk = 1'b0;
	endtask

	// whole frame: opcode, address on ln lines, dummy clocks, nb bits read back
	task automatic frame(input logic [7:0] op, input logic [31:0] adr, input int ab,
			input int ln, input int dc, input int nb,
			output logic [127:0] rd, output logic any);
		logic [3:0] q;
		logic [3:0] m;
		rd = '0;
		oe_seen = 1'b0;
		m = (ln == 4) ? 4'hf : (ln == 2) ? 4'h3 : 4'h1;
		o_cs_n = 1'b0;
		#62.5;
		for (int i = 7; i >= 0; i--) tick({3'h0, op[i]}, 4'h1, q);
		for (int i = ab - ln; i >= 0; i -= ln) tick(4'(adr >> i), m, q);
		for (int i = 0; i < dc; i++) tick(4'h0, 4'h1, q);
		for (int i = 0; i < nb; i += ln) begin
			tick(4'h0, 4'h0, q);
			if (ln == 1) rd = {rd[126:0], q[1]};
			else if (ln == 2) rd = {rd[125:0], q[1:0]};
			else rd = {rd[123:0], q};
		end
		o_cs_n = 1'b1;
		drv = ~drv;
		#100;
		any = oe_seen;
	endtask
endmodule

// File: fls_id_cmds_test.sv
`timescale 1ns/10ps
`include "fls_params.svh"
module fls_id_cmds_test;
	localparam logic [127:0] UID = 128'h0123456789abcdeffedcba9876543210; // arbitrary
	localparam logic [7:0] MK = 8'ha5; // arbitrary
	localparam logic [7:0] DV = 8'h96; // arbitrary
	localparam logic [7:0] MT = 8'h20; // arbitrary
	localparam logic [7:0] CP = 8'h19; // arbitrary
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic busy = 1'b0;
	logic pf = 1'b0;
	logic ef = 1'b0;
	logic sclk;
	logic cs_n;
	logic [3:0] io_in;
	logic [3:0] io_out;
	logic [3:0] io_oe;
	logic alf, perr, eerr, write_in_progress, dpd, rec;
	logic [127:0] rd;
	logic any;
	int failures = 0;
	int comparisons = 0;

	//////////////////////////////////////////////////////////////////
	// core clock, 8 ns
	always #4 i_core_clk = ~i_core_clk;

	fls_id_cmds #(.UID_VALUE(UID), .MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT),
			.CAPACITY(CP)) DUT (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_io_in(io_in), .i_cycle_busy(busy), .i_program_fail(pf), .i_erase_fail(ef),
		.o_io_out(io_out), .o_io_oe(io_oe), .o_addr_len_flag(alf),
		.o_program_error_flag(perr), .o_erase_error_flag(eerr),
		.o_write_in_progress(write_in_progress), .o_deep_power_down(dpd), .o_recovering(rec));

	fls_host_model u_host (
		.i_io_out(io_out), .i_io_oe(io_oe), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(io_in));

	//////////////////////////////////////////////////////////////////
	// comparison, verdict and small helpers
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		// step off the edge so outputs are settled when looked at
		#1;
	endtask

	task automatic lone(input logic [7:0] op);
		u_host.frame(op, 32'h0, 0, 1, 0, 0, rd, any);
	endtask

	//////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		check({alf, perr, eerr, write_in_progress, dpd, rec, io_oe}, 10'h000);
		$display("t_reset done");
	endtask

	task automatic t_ident;
		u_host.frame(`FLS_OP_IDENT3, 32'h0, 0, 1, 0, 5, rd, any);
		check(io_oe, 4'h0);
		u_host.frame(`FLS_OP_IDENT3, 32'h0, 0, 1, 0, 40, rd, any);
		check(rd[39:0], {MK, MT, CP, MK, MT});
		$display("t_ident done");
	endtask

	task automatic t_uid;
		u_host.frame(`FLS_OP_UID, 32'h0, 0, 1, 32, 128, rd, any);
		check(rd, UID);
		lone(`FLS_OP_WIDE_ON);
		check(alf, 1'b1);
		u_host.frame(`FLS_OP_UID, 32'h0, 0, 1, 40, 128, rd, any);
		check(rd, UID);
		u_host.frame(`FLS_OP_MDID_1, 32'h1, 32, 1, 0, 16, rd, any);
		check(rd[15:0], {DV, MK});
		lone(`FLS_OP_WIDE_OFF);
		check(alf, 1'b0);
		u_host.frame(`FLS_OP_UID, 32'h0, 0, 1, 32, 128, rd, any);
		check(rd, UID);
		$display("t_uid done");
	endtask

	task automatic t_mdid;
		int ln;
		logic [7:0] op;
		for (int k = 0; k < 6; k++) begin
			ln = (k < 2) ? 1 : (k < 4) ? 2 : 4;
			op = (ln == 1) ? `FLS_OP_MDID_1 : (ln == 2) ? `FLS_OP_MDID_2 : `FLS_OP_MDID_4;
			u_host.frame(op, 32'(k % 2), 24, ln, 0, 32, rd, any);
			check(rd[31:0], (k % 2) ? {DV, MK, DV, MK} : {MK, DV, MK, DV});
		end
		$display("t_mdid done");
	endtask

	task automatic t_devid;
		u_host.frame(`FLS_OP_RELEASE, 32'h0, 0, 1, 24, 16, rd, any);
		check(rd[15:0], {DV, DV});
		check({dpd, rec}, 2'b00);
		$display("t_devid done");
	endtask

	task automatic t_busy;
		@(posedge i_core_clk) pf <= 1'b1;
		@(posedge i_core_clk) begin
			pf <= 1'b0;
			ef <= 1'b1;
		end
		@(posedge i_core_clk) ef <= 1'b0;
		busy <= 1'b1;
		cyc(4);
		check({write_in_progress, perr, eerr}, 3'h7);
		lone(`FLS_OP_CLR_FLAGS);
		check({perr, eerr}, 2'h3);
		u_host.frame(`FLS_OP_IDENT3, 32'h0, 0, 1, 0, 24, rd, any);
		check(any, 1'b0);
		u_host.frame(`FLS_OP_RELEASE, 32'h0, 0, 1, 24, 16, rd, any);
		check(any, 1'b0);
		@(posedge i_core_clk) busy <= 1'b0;
		cyc(4);
		check(write_in_progress, 1'b0);
		lone(`FLS_OP_CLR_FLAGS);
		check({perr, eerr}, 2'h0);
		$display("t_busy done");
	endtask

	task automatic t_pd;
		int n;
		n = 0;
		lone(`FLS_OP_DEEP_PD);
		check(dpd, 1'b1);
		lone(`FLS_OP_WIDE_ON);
		check(alf, 1'b0);
		u_host.frame(`FLS_OP_MDID_1, 32'h0, 24, 1, 0, 16, rd, any);
		check(any, 1'b0);
		lone(`FLS_OP_RELEASE);
		check({dpd, rec}, 2'b01);
		while (rec === 1'b1 && n < 1000) begin
			@(posedge i_core_clk);
			n++;
		end
		if (n >= 1000) begin
			failures++;
			complete_run;
		end
		check(n >= `FLS_REL_CYC - 13 && n <= `FLS_REL_CYC - 7, 1'b1);
		u_host.frame(`FLS_OP_IDENT3, 32'h0, 0, 1, 0, 24, rd, any);
		check(rd[23:0], {MK, MT, CP});
		$display("t_pd done");
	endtask

	//////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (6) @(posedge i_core_clk);
		i_reset <= 1'b0;
		cyc(4);
		t_reset;
		t_ident;
		t_uid;
		t_mdid;
		t_devid;
		t_busy;
		t_pd;
		complete_run;
	end
endmodule
